// ### include/acp_pkg.sv
// Shared constants for the auxiliary control plane register bank
package acp_pkg;

    // Register indices; the bus byte address is four times the index
    localparam logic [5:0] IDX_RELOAD = 6'h01;
    localparam logic [5:0] IDX_PRESCALE = 6'h02;
    localparam logic [5:0] IDX_PWRDN = 6'h03;
    localparam logic [5:0] IDX_WDOG = 6'h04;
    localparam logic [5:0] IDX_WKT = 6'h08;
    localparam logic [5:0] IDX_MODE_LO = 6'h0c;
    localparam logic [5:0] IDX_MODE_HI = 6'h0d;
    localparam logic [5:0] IDX_HSINK = 6'h0e;
    localparam logic [5:0] IDX_STATUS = 6'h10;

    // Widths
    localparam int unsigned TMR_W = 8;
    localparam int unsigned PSC_W = 4;
    localparam int unsigned MODE_W = 2;

    // Reset values
    localparam logic [7:0] RST_RELOAD = 8'h00;
    localparam logic [3:0] RST_PSC = 4'h0;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [7:0] RST_HSINK = 8'h00;

    // Field positions of the pin mode fields
    localparam int unsigned PIN7_LSB = 6;
    localparam int unsigned PIN6_LSB = 4;
    localparam int unsigned PIN5_LSB = 2;
    localparam int unsigned PIN4_LSB = 0;
    localparam int unsigned PIN3_LSB = 6;

    // Pin mode codes
    localparam logic [1:0] MODE_OD = 2'h0;
    localparam logic [1:0] MODE_PP = 2'h1;
    localparam logic [1:0] MODE_IN_PAD = 2'h2;
    localparam logic [1:0] MODE_IN_CMP = 2'h3;

    // Prescaler: largest code served, and base ticks between steps less one
    localparam logic [3:0] PSC_MAX = 4'h7;
    localparam logic [7:0] PSC_GAP [8] = '{8'h01, 8'h03, 8'h07, 8'h0f,
                                           8'h1f, 8'h3f, 8'h7f, 8'hff};
    localparam logic [7:0] TMR_MAX = 8'hff;

    // Status word bit positions
    localparam int unsigned ST_WDOG = 0;
    localparam int unsigned ST_PWRDN = 1;
    localparam int unsigned ST_CNT_LSB = 8;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : acp_pkg

// ### include/acp_timer_if.sv
// Link between the register bank and its timer
interface acp_timer_if;
    import acp_pkg::*;
    logic [TMR_W-1:0] reload;
    logic [PSC_W-1:0] prescale;
    logic [TMR_W-1:0] count;
    logic overflow;
    modport ctrl (output reload, output prescale, input count, input overflow);
    modport timer (input reload, input prescale, output count, output overflow);
endinterface : acp_timer_if

// ### core/acp_timer.sv
// Prescaler and reloading eight-bit timer steered by the register bank
module acp_timer
    import acp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_instr_tick,
    acp_timer_if.timer tif
);
    logic phase_q, phase_d;
    logic [7:0] psc_q, psc_d;
    logic [TMR_W-1:0] cnt_q, cnt_d;
    logic ovf_q, ovf_d;
    logic base;
    logic step;
    logic [3:0] code_eff;
    logic [8:0] mask_w;
    logic [7:0] mask;

    // Base tick every second instruction cycle, then a power-of-two divider
    always_comb begin
        code_eff = (tif.prescale > PSC_MAX) ? PSC_MAX : tif.prescale;
        mask_w = (9'h001 << ({1'b0, code_eff} + 5'h01)) - 9'h001;
        mask = mask_w[7:0];
        base = i_instr_tick && phase_q;
        phase_d = i_instr_tick ? !phase_q : phase_q;
        psc_d = base ? psc_q + 8'h01 : psc_q;
        step = base && ((psc_q & mask) == mask);
        cnt_d = cnt_q;
        ovf_d = 1'b0;
        if (step) begin
            if (cnt_q == TMR_MAX) begin
                cnt_d = tif.reload;
                ovf_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            phase_q <= 1'b0;
            psc_q <= 8'h00;
            cnt_q <= 8'h00;
            ovf_q <= 1'b0;
        end else if (i_clk_en) begin
            phase_q <= phase_d;
            psc_q <= psc_d;
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
        end
    end

    assign tif.count = cnt_q;
    assign tif.overflow = ovf_q;

    // Helpers that watch step spacing independently of the mask
    logic [7:0] since_q;
    logic seen_q;
    logic [3:0] code_prev_q;
    logic last_base_q;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            since_q <= 8'h00;
            seen_q <= 1'b0;
            code_prev_q <= 4'h0;
            last_base_q <= 1'b0;
        end else if (i_clk_en) begin
            code_prev_q <= tif.prescale;
            if (tif.prescale != code_prev_q) begin
                seen_q <= 1'b0;
            end else if (step) begin
                seen_q <= 1'b1;
            end
            if (base) begin
                since_q <= step ? 8'h00 : since_q + 8'h01;
            end
            if (i_instr_tick) begin
                last_base_q <= base;
            end
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    reload_on_wrap_a: assert property ($rose(ovf_q) |-> cnt_q == $past(tif.reload))
        else $error("timer not reloaded on overflow");
    prescale_gap_a: assert property (
        step && i_clk_en && seen_q && tif.prescale == code_prev_q
        |-> since_q == PSC_GAP[code_eff[2:0]])
        else $error("prescaler step spacing wrong");
    base_tick_half_a: assert property (
        i_clk_en && i_instr_tick && last_base_q |-> !base)
        else $error("base tick on consecutive instruction cycles");

endmodule : acp_timer

// ### core/acp_aux_regs.sv
// Auxiliary control plane register bank behind an AXI4-Lite slave
//
// The AXI4-Lite register port is this design's own decision.

// Function
// - Timer reloads from written value on overflow
// - Prescale codes 0,1,7 divide by 2,4,256
// - Prescaler counts two-instruction-cycle base ticks
// - Any power-down write enters power-down
// - Watchdog write clears and enables watchdog
// - Wake-up timer write restarts its count
// - One high-sink select bit per pin
// - Modes: open-drain, push-pull, pad input
// - Pin three code 11 reads comparator
module acp_aux_regs
    import acp_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_instr_tick,
    input wire logic i_wake_event,
    input wire logic i_pd3_pad,
    input wire logic i_comparator,
    input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [ADDR_W-1:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [TMR_W-1:0] o_timer_count,
    output logic o_timer_overflow,
    output logic o_power_down_req,
    output logic o_power_down,
    output logic o_watchdog_clear,
    output logic o_watchdog_enable,
    output logic o_wakeup_timer_clear,
    output logic [7:0] o_port_d_high_sink_select,
    output logic [1:0] o_port_d_pin7_mode,
    output logic [1:0] o_port_d_pin6_mode,
    output logic [1:0] o_port_d_pin5_mode,
    output logic [1:0] o_port_d_pin4_mode,
    output logic [1:0] o_port_d_pin3_mode,
    output logic [4:0] o_port_d_push_pull,
    output logic [4:0] o_port_d_input_mode,
    output logic o_port_d_pin3_in
);
    localparam int unsigned IW = ADDR_W - 2;

    // The status index needs seven address bits; wider maps waste decode
    if (ADDR_W < 7 || ADDR_W > 16) begin : g_addr_check
        $error("acp_aux_regs: ADDR_W must lie in 7..16");
    end

    // True for every index that accepts writes
    function automatic logic is_wr_idx(input logic [IW-1:0] ix);
        return ix == IW'(IDX_RELOAD) || ix == IW'(IDX_PRESCALE) ||
               ix == IW'(IDX_PWRDN) || ix == IW'(IDX_WDOG) ||
               ix == IW'(IDX_WKT) || ix == IW'(IDX_MODE_LO) ||
               ix == IW'(IDX_MODE_HI) || ix == IW'(IDX_HSINK);
    endfunction : is_wr_idx

    acp_timer_if tif ();

    // ---- Write channel state
    logic aw_got_q, aw_got_d;
    logic w_got_q, w_got_d;
    logic [IW-1:0] aw_idx_q, aw_idx_d;
    logic [7:0] wdata_q, wdata_d;
    logic wstrb0_q, wstrb0_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic aw_take;
    logic w_take;
    logic do_write;

    // Address and data may arrive in either order; the write lands once
    // both are held, and the response follows in the same edge
    always_comb begin
        aw_take = i_s_axi_awvalid && awready_q;
        w_take = i_s_axi_wvalid && wready_q;
        do_write = aw_got_q && w_got_q && !bvalid_q;
        aw_got_d = aw_got_q || aw_take;
        w_got_d = w_got_q || w_take;
        aw_idx_d = aw_take ? i_s_axi_awaddr[ADDR_W-1:2] : aw_idx_q;
        wdata_d = w_take ? i_s_axi_wdata[7:0] : wdata_q;
        wstrb0_d = w_take ? i_s_axi_wstrb[0] : wstrb0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (do_write) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = is_wr_idx(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && i_s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // Only one write in flight: no new beat until the answer is taken
        awready_d = !aw_got_d && !bvalid_d;
        wready_d = !w_got_d && !bvalid_d;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_idx_q <= '0;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end else if (i_clk_en) begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            aw_idx_q <= aw_idx_d;
            wdata_q <= wdata_d;
            wstrb0_q <= wstrb0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
        end
    end

    // ---- Control registers and strobes
    logic [7:0] reload_q, reload_d;
    logic [3:0] psc_q, psc_d;
    logic [7:0] hsink_q, hsink_d;
    logic [7:0] mode_hi_q, mode_hi_d;
    logic [1:0] mode3_q, mode3_d;
    logic pd_req_q, pd_req_d;
    logic pd_q, pd_d;
    logic wdc_q, wdc_d;
    logic wde_q, wde_d;
    logic wkc_q, wkc_d;
    logic data_wr;

    // Strobe locations fire on any write whatever the data or byte lanes;
    // data registers only take a write that carries byte lane zero
    always_comb begin
        data_wr = do_write && wstrb0_q;
        reload_d = reload_q;
        psc_d = psc_q;
        hsink_d = hsink_q;
        mode_hi_d = mode_hi_q;
        mode3_d = mode3_q;
        if (data_wr && aw_idx_q == IW'(IDX_RELOAD)) begin
            reload_d = wdata_q;
        end
        if (data_wr && aw_idx_q == IW'(IDX_PRESCALE)) begin
            psc_d = wdata_q[PSC_W-1:0];
        end
        if (data_wr && aw_idx_q == IW'(IDX_HSINK)) begin
            hsink_d = wdata_q;
        end
        if (data_wr && aw_idx_q == IW'(IDX_MODE_HI)) begin
            mode_hi_d = wdata_q;
        end
        if (data_wr && aw_idx_q == IW'(IDX_MODE_LO)) begin
            mode3_d = wdata_q[PIN3_LSB +: MODE_W];
        end
        pd_req_d = do_write && aw_idx_q == IW'(IDX_PWRDN);
        // A new power-down request wins over a wake in the same cycle
        pd_d = pd_req_d || (pd_q && !i_wake_event);
        wdc_d = do_write && aw_idx_q == IW'(IDX_WDOG);
        wde_d = wde_q || wdc_d;
        wkc_d = do_write && aw_idx_q == IW'(IDX_WKT);
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            reload_q <= RST_RELOAD;
            psc_q <= RST_PSC;
            hsink_q <= RST_HSINK;
            mode_hi_q <= {4{RST_MODE}};
            mode3_q <= RST_MODE;
            pd_req_q <= 1'b0;
            pd_q <= 1'b0;
            wdc_q <= 1'b0;
            wde_q <= 1'b0;
            wkc_q <= 1'b0;
        end else if (i_clk_en) begin
            reload_q <= reload_d;
            psc_q <= psc_d;
            hsink_q <= hsink_d;
            mode_hi_q <= mode_hi_d;
            mode3_q <= mode3_d;
            pd_req_q <= pd_req_d;
            pd_q <= pd_d;
            wdc_q <= wdc_d;
            wde_q <= wde_d;
            wkc_q <= wkc_d;
        end
    end

    // ---- Pin mode decode, registered so every output leaves a flop
    logic [9:0] modes;
    logic [4:0] pp_q, pp_d;
    logic [4:0] inm_q, inm_d;
    logic pin3_in_q, pin3_in_d;

    always_comb begin
        modes = {mode_hi_q, mode3_q};
        for (int i = 0; i < 5; i++) begin
            pp_d[i] = modes[2*i +: 2] == MODE_PP;
            inm_d[i] = modes[2*i + 1];
        end
        // Only pin three offers the comparator; it bypasses the pad here
        pin3_in_d = (mode3_q == MODE_IN_CMP) ? i_comparator : i_pd3_pad;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pp_q <= 5'h00;
            inm_q <= 5'h00;
            pin3_in_q <= 1'b0;
        end else if (i_clk_en) begin
            pp_q <= pp_d;
            inm_q <= inm_d;
            pin3_in_q <= pin3_in_d;
        end
    end

    // ---- Read channel
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [IW-1:0] ar_idx;

    // Write-only locations read as zero; only the status word has content
    always_comb begin
        ar_idx = i_s_axi_araddr[ADDR_W-1:2];
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (i_s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d = 32'h0000_0000;
            rresp_d = RESP_OKAY;
            if (ar_idx == IW'(IDX_STATUS)) begin
                rdata_d[ST_WDOG] = wde_q;
                rdata_d[ST_PWRDN] = pd_q;
                rdata_d[ST_CNT_LSB +: TMR_W] = tif.count;
            end else if (!is_wr_idx(ar_idx)) begin
                rresp_d = RESP_SLVERR;
            end
        end else if (rvalid_q && i_s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (i_clk_en) begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // ---- Timer and output wiring
    assign tif.reload = reload_q;
    assign tif.prescale = psc_q;

    acp_timer u_timer (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_instr_tick(i_instr_tick),
        .tif(tif.timer)
    );

    assign o_s_axi_awready = awready_q;
    assign o_s_axi_wready = wready_q;
    assign o_s_axi_bresp = bresp_q;
    assign o_s_axi_bvalid = bvalid_q;
    assign o_s_axi_arready = arready_q;
    assign o_s_axi_rdata = rdata_q;
    assign o_s_axi_rresp = rresp_q;
    assign o_s_axi_rvalid = rvalid_q;
    assign o_timer_count = tif.count;
    assign o_timer_overflow = tif.overflow;
    assign o_power_down_req = pd_req_q;
    assign o_power_down = pd_q;
    assign o_watchdog_clear = wdc_q;
    assign o_watchdog_enable = wde_q;
    assign o_wakeup_timer_clear = wkc_q;
    assign o_port_d_high_sink_select = hsink_q;
    assign o_port_d_pin7_mode = mode_hi_q[PIN7_LSB +: MODE_W];
    assign o_port_d_pin6_mode = mode_hi_q[PIN6_LSB +: MODE_W];
    assign o_port_d_pin5_mode = mode_hi_q[PIN5_LSB +: MODE_W];
    assign o_port_d_pin4_mode = mode_hi_q[PIN4_LSB +: MODE_W];
    assign o_port_d_pin3_mode = mode3_q;
    assign o_port_d_push_pull = pp_q;
    assign o_port_d_input_mode = inm_q;
    assign o_port_d_pin3_in = pin3_in_q;

    // ---- Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    sequence wr_at(logic [5:0] ix);
        do_write && i_clk_en && aw_idx_q == IW'(ix);
    endsequence

    sequence wr_data_at(logic [5:0] ix);
        wr_at(ix) ##0 wstrb0_q;
    endsequence

    power_down_entry_a: assert property (
        wr_at(IDX_PWRDN) |=> o_power_down_req && o_power_down && o_s_axi_bvalid)
        else $error("power-down write had no effect");
    watchdog_kick_a: assert property (
        wr_at(IDX_WDOG) |=> o_watchdog_clear && o_watchdog_enable ##1 o_watchdog_enable)
        else $error("watchdog write did not clear and enable");
    wakeup_clear_a: assert property (
        wr_at(IDX_WKT) |=> o_wakeup_timer_clear && !o_power_down_req)
        else $error("wake-up timer clear missing");
    high_sink_write_a: assert property (
        wr_data_at(IDX_HSINK) |=> o_port_d_high_sink_select == $past(wdata_q))
        else $error("high-sink select not stored");
    mode_decode_a: assert property (
        i_clk_en |=> o_port_d_push_pull[4] == ($past(o_port_d_pin7_mode) == MODE_PP)
        && o_port_d_input_mode[0] == $past(o_port_d_pin3_mode[1]))
        else $error("pin mode decode wrong");
    comparator_route_a: assert property (
        i_clk_en |=> o_port_d_pin3_in == ($past(o_port_d_pin3_mode) == MODE_IN_CMP
        ? $past(i_comparator) : $past(i_pd3_pad)))
        else $error("pin three input source wrong");
    mode_layout_a: assert property (
        wr_data_at(IDX_MODE_HI) |=> o_port_d_pin7_mode == $past(wdata_q[7:6])
        && o_port_d_pin4_mode == $past(wdata_q[1:0]))
        else $error("high pin mode fields misplaced");
    prescale_reg_a: assert property (
        wr_data_at(IDX_PRESCALE) |=> tif.prescale == $past(wdata_q[3:0]))
        else $error("prescale select not stored");

endmodule : acp_aux_regs

// ### tb/tb_acp_aux_regs.sv
// Self-checking bench for the auxiliary control plane register bank
module tb_acp_aux_regs
    import acp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic tick = 1'b0;
    logic en = 1'b1;
    logic wake = 1'b0;
    logic pad = 1'b0;
    logic cmp = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] count, hsink;
    logic ovf, pd_req, pd, wd_clr, wd_en, wk_clr, pin3_in;
    logic [1:0] m7, m6, m5, m4, m3;
    logic [4:0] push_pull, in_mode;
    logic [2:0] strobes;
    int fails = 0;
    int check_count = 0;

    // 100 MHz clock
    always #5 i_clock = ~i_clock;

    acp_aux_regs dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(en),
        .i_instr_tick(tick), .i_wake_event(wake), .i_pd3_pad(pad), .i_comparator(cmp),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_timer_count(count),
        .o_timer_overflow(ovf), .o_power_down_req(pd_req), .o_power_down(pd),
        .o_watchdog_clear(wd_clr), .o_watchdog_enable(wd_en),
        .o_wakeup_timer_clear(wk_clr), .o_port_d_high_sink_select(hsink),
        .o_port_d_pin7_mode(m7), .o_port_d_pin6_mode(m6), .o_port_d_pin5_mode(m5),
        .o_port_d_pin4_mode(m4), .o_port_d_pin3_mode(m3), .o_port_d_push_pull(push_pull),
        .o_port_d_input_mode(in_mode), .o_port_d_pin3_in(pin3_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // Write one word; strobe outputs are captured at the response edge
    task automatic axi_write(input logic [5:0] idx, input logic [7:0] data,
                             input logic [3:0] strb, input logic [1:0] exp_resp);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        @(posedge i_clock);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, data};
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got && n < 50) begin
            @(posedge i_clock);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                got = 1'b1;
                strobes = {pd_req, wd_clr, wk_clr};
                check({30'h0, bresp}, {30'h0, exp_resp});
                bready <= 1'b0;
            end
        end
        if (!got) check(32'h0, 32'h1);
    endtask : axi_write

    // Read one word and compare data and response
    task automatic axi_read(input logic [5:0] idx, input logic [31:0] exp,
                            input logic [1:0] exp_resp);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        @(posedge i_clock);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got && n < 50) begin
            @(posedge i_clock);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                got = 1'b1;
                check(rdata, exp);
                check({30'h0, rresp}, {30'h0, exp_resp});
                rready <= 1'b0;
            end
        end
        if (!got) check(32'h0, 32'h1);
    endtask : axi_read

    // Cycles until the next overflow pulse, bounded
    task automatic wait_ovf(output int n);
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (ovf !== 1'b1 && n < 3000);
        if (n >= 3000) check(32'h0, 32'h1);
    endtask : wait_ovf

    // Watchdog sized well above the longest timer sweep
    initial begin
        repeat (60000) @(posedge i_clock);
        fails++;
        final_report;
    end

    logic [5:0] sidx [3] = '{IDX_PWRDN, IDX_WDOG, IDX_WKT};
    logic [2:0] sexp [3] = '{3'b100, 3'b010, 3'b001};

    initial begin
        int n;
        int c;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        // Everything starts cleared; timer frozen while tick stays low
        check(32'({m7, m6, m5, m4, m3, hsink}), 32'h0);
        check(32'({pd, wd_en, count}), 32'h0);
        axi_read(IDX_RELOAD, 32'h0, RESP_OKAY);
        axi_read(IDX_STATUS, 32'h0, RESP_OKAY);
        // Strobes fire with zero data and no byte lane set, each alone
        for (int i = 0; i < 3; i++) begin
            axi_write(sidx[i], 8'h00, 4'h0, RESP_OKAY);
            check(32'(strobes), 32'(sexp[i]));
        end
        check(32'({pd, wd_en}), 32'h3);
        axi_read(IDX_STATUS, 32'h3, RESP_OKAY);
        // Clock enable low must freeze the flag although wake is up
        en <= 1'b0;
        wake <= 1'b1;
        repeat (3) @(posedge i_clock);
        check(32'({pd, wd_en}), 32'h3);
        en <= 1'b1;
        @(posedge i_clock);
        wake <= 1'b0;
        repeat (2) @(posedge i_clock);
        check(32'({pd, wd_en}), 32'h1);
        // Unmapped and read-only places are refused
        axi_write(6'h05, 8'hff, 4'hf, RESP_SLVERR);
        axi_read(6'h05, 32'h0, RESP_SLVERR);
        axi_write(IDX_STATUS, 8'hff, 4'hf, RESP_SLVERR);
        // High sink bits map one per pin
        axi_write(IDX_HSINK, 8'ha5, 4'h1, RESP_OKAY);
        check(32'(hsink), 32'ha5);
        axi_write(IDX_HSINK, 8'h5a, 4'h1, RESP_OKAY);
        check(32'(hsink), 32'h5a);
        // Upper pins get every code at once, pin 3 steps through all four
        axi_write(IDX_MODE_HI, 8'h1b, 4'h1, RESP_OKAY);
        check(32'({m7, m6, m5, m4}), 32'h1b);
        for (c = 0; c < 4; c++) begin
            axi_write(IDX_MODE_LO, 8'(c << 6), 4'h1, RESP_OKAY);
            // Pad and comparator differ, so the chosen source shows
            pad <= c[0];
            cmp <= !c[0];
            repeat (3) @(posedge i_clock);
            check(32'(m3), 32'(c));
            check(32'(push_pull), 32'({4'b0100, c == 1}));
            check(32'(in_mode), 32'({4'b0011, c >= 2}));
            check(32'(pin3_in), (c == 3) ? 32'h0 : 32'(c[0]));
        end
        // Timer: two steps per wrap from reload fe; period doubles per code up to 7, code 8 clamps to 7
        tick <= 1'b1;
        axi_write(IDX_RELOAD, 8'hfe, 4'h1, RESP_OKAY);
        axi_write(IDX_RELOAD, 8'h80, 4'h0, RESP_OKAY);
        for (c = 0; c < 9; c++) begin
            axi_write(IDX_PRESCALE, 8'(c), 4'h1, RESP_OKAY);
            wait_ovf(n);
            check(32'(count), 32'hfe);
            wait_ovf(n);
            wait_ovf(n);
            check(n, 8 << ((c > 7) ? 7 : c));
        end
        final_report;
    end
endmodule : tb_acp_aux_regs
